// ---- shared/ocs_pkg.sv ----
// Constants and types shared by the optical module control and status logic
package ocs_pkg;

  // ==========================================================================
  // Clock
  localparam int CLK_PERIOD_NS = 10;

  // ==========================================================================
  // Timing figures, in their own units, and derived cycle counts
  localparam int T_OFF_US = 10;      // Longest time to extinguish the output
  localparam int T_ON_MS = 1;        // Longest time to restore the output
  localparam int T_FAULT_US = 100;   // Longest fault indication latency
  localparam int T_RESET_US = 10;    // Least shut-off pulse that clears a fault
  localparam int T_LOSS_US = 100;    // Longest loss indication latency
  localparam int T_OFF_CYC = (T_OFF_US * 1000) / CLK_PERIOD_NS;
  localparam int T_ON_CYC = (T_ON_MS * 1000000) / CLK_PERIOD_NS;
  localparam int T_FAULT_CYC = (T_FAULT_US * 1000) / CLK_PERIOD_NS;
  localparam int T_RESET_CYC = (T_RESET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_LOSS_CYC = (T_LOSS_US * 1000) / CLK_PERIOD_NS;
  localparam int OFF_CNT_W = $clog2(T_RESET_CYC + 1);
  localparam logic [OFF_CNT_W-1:0] OFF_CNT_MAX = OFF_CNT_W'(T_RESET_CYC);

  // ==========================================================================
  // Synchronised pin indices and their reset levels
  localparam int PIN_N = 6;
  localparam int PIN_TX_OFF = 0;
  localparam int PIN_FAULT = 1;
  localparam int PIN_RX_LOW = 2;
  localparam int PIN_RX_OK = 3;
  localparam int PIN_SCL = 4;
  localparam int PIN_SDA = 5;
  localparam logic [PIN_N-1:0] PIN_RST = 6'h31;  // Shut-off, clock, data idle high

  // ==========================================================================
  // Two-wire identification and diagnostics port
  localparam logic [6:0] ID_ADDR = 7'h50;
  localparam logic [6:0] DIAG_ADDR = 7'h51;
  localparam int ID_DEPTH = 32;
  localparam logic [7:0] ID_LIMIT = 8'h20;
  localparam int DG_CHANNELS = 5;             // Temp, supply, bias, tx power, rx power
  localparam logic [7:0] DG_LIMIT = 8'h0A;    // Two bytes per channel, high byte first
  localparam logic [3:0] BIT_FULL = 4'h8;
  localparam logic [15:0] CAL_SLOPE_RST = 16'h0100;  // Unity gain
  localparam int CAL_SHIFT = 8;

  typedef enum logic [2:0] {
    TW_IDLE = 3'h0,
    TW_ADDR = 3'h1,
    TW_ACK_A = 3'h2,
    TW_WR = 3'h3,
    TW_ACK_W = 3'h4,
    TW_RD = 3'h5,
    TW_ACK_R = 3'h6
  } ocs_tw_state_type;

endpackage

// ---- design/ocs_pin_sync.sv ----
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module ocs_pin_sync #(
  parameter logic RST_VAL = 1'b0  // Level held through reset
) (
  input wire logic clk,   // System clock
  input wire logic nrst,  // Synchronous reset, active low
  input wire logic pin,   // Asynchronous pin level
  output logic level      // Filtered level
);
  logic s1_r, s2_r, s3_r, lvl_r;

  // ==========================================================================
  // Stages; the first is read only by the second
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      lvl_r <= RST_VAL;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        lvl_r <= s3_r;
      end
    end
  end

  assign level = lvl_r;
endmodule // ocs_pin_sync

// ---- design/ocs_ctrl.sv ----
// Control, status and two-wire identification logic of an optical module
//
// What this block does
// R1: Fault indication within 100 us of fault.
// R2: Fault pin open-drain, released on fault.
// R3: Shut-off high or open turns laser off.
// R4: Shut-off gates laser and clears fault, pulled up default.
// R5: Presence pin held grounded.
// R6: Two module pins are serial clock and data.
// R7: Host keeps serial clock at most 400 kHz.
// R8: Loss pin open-drain, released on loss.
// R9: Serial reads return identification and diagnostics.
// R10: Five monitors, internal or external calibration.
// R11: Output off within 10 us of shut-off.
// R12: Output back within 1 ms of release.
// R13: Host clears fault by 10 us shut-off pulse.
// R14: Loss set and cleared within 100 us.
`timescale 1ns/1ps
module ocs_ctrl #(
  parameter int FAULT_CYC = ocs_pkg::T_FAULT_CYC,  // Fault latency bound in cycles
  parameter int LOSS_CYC = ocs_pkg::T_LOSS_CYC,    // Loss latency bound in cycles
  parameter int ON_CYC = ocs_pkg::T_ON_CYC         // Restore bound in cycles
) (
  input wire logic clk,                 // 100 MHz clock
  input wire logic nrst,                // Synchronous reset, active low
  input wire logic tx_off_i,            // Shut-off pin level, open reads high
  input wire logic fault_cond_i,        // Laser driver fault detector
  input wire logic rx_low_i,            // Rx power below assert threshold
  input wire logic rx_ok_i,             // Rx power above deassert threshold
  output logic laser_on,                // Optical output enable
  output logic fault_o,                 // Fault pin output value
  output logic fault_oe,                // Fault pin pulls low
  output logic lost_o,                  // Signal_lost_flag pin output value
  output logic lost_oe,                 // Signal_lost_flag pin pulls low
  output logic present_o,               // Presence pin output value
  output logic present_oe,              // Presence pin pulls low
  input wire logic scl_i,               // Serial clock pin
  input wire logic sda_i,               // Serial data pin in
  output logic sda_o,                   // Serial data pin out value
  output logic sda_oe,                  // Serial data pin pulls low
  input wire logic cal_ext,             // High reports raw values
  input wire logic [15:0] cal_slope,    // Internal gain, 8.8 fixed point
  input wire logic [15:0] temp_raw,     // Temperature monitor
  input wire logic [15:0] vcc_raw,      // Supply monitor
  input wire logic [15:0] bias_raw,     // Bias current monitor
  input wire logic [15:0] txpwr_raw,    // Transmit power monitor
  input wire logic [15:0] rxpwr_raw     // Receive power monitor
);
  import ocs_pkg::*;
  // ==========================================================================
  // Pin synchronisers
  logic [PIN_N-1:0] pins_raw, pins_s;
  assign pins_raw = {sda_i, scl_i, rx_ok_i, rx_low_i, fault_cond_i, tx_off_i};
  // R4: shut-off held asserted through reset
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_sync
      ocs_pin_sync #(.RST_VAL(PIN_RST[gi])) u_sync (.clk(clk), .nrst(nrst), .pin(pins_raw[gi]), .level(pins_s[gi]));
    end
  endgenerate

  logic tx_off_s, fault_s, rx_low_s, rx_ok_s, scl_s, sda_s;
  assign tx_off_s = pins_s[PIN_TX_OFF];
  assign fault_s = pins_s[PIN_FAULT];
  assign rx_low_s = pins_s[PIN_RX_LOW];
  assign rx_ok_s = pins_s[PIN_RX_OK];
  assign scl_s = pins_s[PIN_SCL];
  assign sda_s = pins_s[PIN_SDA];

  // ==========================================================================
  // Fault latch and shut-off pulse timer
  logic fault_r, fault_nxt, tx_off_d_r, clr_fault, laser_r, lost_r, lost_nxt;
  logic [OFF_CNT_W-1:0] off_cnt_r, off_cnt_nxt;
  // R13: long shut-off pulse clears fault
  assign off_cnt_nxt = !tx_off_s ? '0 : (off_cnt_r == OFF_CNT_MAX) ? off_cnt_r : off_cnt_r + 1'b1;
  assign clr_fault = tx_off_d_r && !tx_off_s && (off_cnt_r == OFF_CNT_MAX);
  // R1: set wins over clear
  assign fault_nxt = fault_s || (fault_r && !clr_fault);
  // R14: hysteresis between the two thresholds
  assign lost_nxt = rx_low_s ? 1'b1 : rx_ok_s ? 1'b0 : lost_r;

  // Status state
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fault_r <= 1'b0;
      tx_off_d_r <= 1'b1;
      off_cnt_r <= '0;
      laser_r <= 1'b0;
      lost_r <= 1'b1;
    end else begin
      fault_r <= fault_nxt;
      tx_off_d_r <= tx_off_s;
      off_cnt_r <= off_cnt_nxt;
      // R3 R11 R12: shut-off or fault keeps laser dark
      laser_r <= !tx_off_s && !fault_nxt;
      lost_r <= lost_nxt;
    end
  end

  assign laser_on = laser_r;
  // R2: released means logic 1 on the pulled-up line
  assign fault_o = 1'b0;
  assign fault_oe = !fault_r;
  // R8: loss releases the line
  assign lost_o = 1'b0;
  assign lost_oe = !lost_r;
  // R5: presence held low at all times
  assign present_o = 1'b0;
  assign present_oe = 1'b1;

  // ==========================================================================
  // Monitor capture with calibration choice
  logic [15:0] raw [DG_CHANNELS];
  logic [15:0] diag_r [DG_CHANNELS];
  assign raw[0] = temp_raw;
  assign raw[1] = vcc_raw;
  assign raw[2] = bias_raw;
  assign raw[3] = txpwr_raw;
  assign raw[4] = rxpwr_raw;

  generate
    for (gi = 0; gi < DG_CHANNELS; gi++) begin : g_diag
      logic [31:0] prod;
      assign prod = raw[gi] * cal_slope;
      // R10: raw for external, scaled for internal
      always_ff @(posedge clk) begin
        if (!nrst) begin
          diag_r[gi] <= '0;
        end else begin
          diag_r[gi] <= cal_ext ? raw[gi] : prod[CAL_SHIFT+15:CAL_SHIFT];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Two-wire slave
  ocs_tw_state_type st_r, st_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt, rd_byte, id_byte, dg_byte;
  logic sel_r, sel_nxt, rw_r, rw_nxt, first_r, first_nxt, we;
  logic scl_d_r, sda_d_r, scl_rise, scl_fall, start_c, stop_c, addr_hit;
  logic [7:0] id_mem [ID_DEPTH];

  // R6: framing decoded from the clock and data pins
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_c = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_c = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign addr_hit = (sh_r[7:1] == ID_ADDR) || (sh_r[7:1] == DIAG_ADDR);
  // R9: byte source for reads; outside either area reads zero
  assign id_byte = (ptr_r < ID_LIMIT) ? id_mem[ptr_r[4:0]] : 8'h00;
  assign dg_byte = (ptr_r >= DG_LIMIT) ? 8'h00 :
                   ptr_r[0] ? diag_r[ptr_r[3:1]][7:0] : diag_r[ptr_r[3:1]][15:8];
  assign rd_byte = sel_r ? dg_byte : id_byte;

  // Slave sequencer; bits in on rising clock, out on falling clock
  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    sel_nxt = sel_r;
    rw_nxt = rw_r;
    first_nxt = first_r;
    we = 1'b0;
    if (stop_c) begin
      st_nxt = TW_IDLE;
    end else if (start_c) begin
      st_nxt = TW_ADDR;
      bit_nxt = 4'h0;
    end else if (scl_rise) begin
      if (st_r == TW_ADDR || st_r == TW_WR) begin
        sh_nxt = {sh_r[6:0], sda_s};
        bit_nxt = bit_r + 4'h1;
      end else if (st_r == TW_RD) begin
        bit_nxt = bit_r + 4'h1;
      end else if (st_r == TW_ACK_R && sda_s) begin
        st_nxt = TW_IDLE;  // Master declined further bytes
      end
    end else if (scl_fall) begin
      unique case (st_r)
        TW_IDLE: st_nxt = TW_IDLE;
        TW_ADDR: begin
          if (bit_r == BIT_FULL) begin
            st_nxt = addr_hit ? TW_ACK_A : TW_IDLE;
            sel_nxt = (sh_r[7:1] == DIAG_ADDR);
            rw_nxt = sh_r[0];
          end
        end
        TW_ACK_A: begin
          bit_nxt = 4'h0;
          first_nxt = 1'b1;
          st_nxt = rw_r ? TW_RD : TW_WR;
          sh_nxt = rw_r ? rd_byte : sh_r;
        end
        TW_WR: begin
          if (bit_r == BIT_FULL) begin
            st_nxt = TW_ACK_W;
            first_nxt = 1'b0;
            we = !first_r && !sel_r && (ptr_r < ID_LIMIT);
            ptr_nxt = first_r ? sh_r : ptr_r + 8'h01;
          end
        end
        TW_ACK_W: begin
          st_nxt = TW_WR;
          bit_nxt = 4'h0;
        end
        TW_RD: begin
          if (bit_r == BIT_FULL) begin
            st_nxt = TW_ACK_R;
            ptr_nxt = ptr_r + 8'h01;
          end else begin
            sh_nxt = {sh_r[6:0], 1'b0};
          end
        end
        TW_ACK_R: begin
          st_nxt = TW_RD;
          bit_nxt = 4'h0;
          sh_nxt = rd_byte;
        end
        default: st_nxt = TW_IDLE;
      endcase
    end
  end

  // Slave registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r <= TW_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'hFF;
      ptr_r <= 8'h00;
      sel_r <= 1'b0;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      sel_r <= sel_nxt;
      rw_r <= rw_nxt;
      first_r <= first_nxt;
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // Identification store, no reset so it maps onto plain memory
  always_ff @(posedge clk) begin
    if (we) begin
      id_mem[ptr_r[4:0]] <= sh_r;
    end
  end

  // R9: acknowledge and read data drive the line low only
  assign sda_o = 1'b0;
  assign sda_oe = (st_r == TW_ACK_A) || (st_r == TW_ACK_W) || ((st_r == TW_RD) && !sh_r[7]);

  // ==========================================================================
  // Checks
  logic [31:0] fault_wait_r, on_wait_r, loss_wait_r;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fault_wait_r <= '0;
      on_wait_r <= '0;
      loss_wait_r <= '0;
    end else begin
      fault_wait_r <= (fault_s && fault_oe) ? fault_wait_r + 1 : '0;
      on_wait_r <= (!tx_off_s && !fault_r && !laser_r) ? on_wait_r + 1 : '0;
      loss_wait_r <= ((rx_low_s && lost_oe) || (rx_ok_s && !rx_low_s && !lost_oe)) ? loss_wait_r + 1 : '0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_fault_bound: assert property (fault_wait_r < FAULT_CYC) else $error("fault indication too late"); // R1
  a_fault_pin: assert property ($rose(fault_s) |=> !fault_oe [*2]) else $error("fault pin not released"); // R2
  a_laser_off: assert property (tx_off_s |=> !laser_on) else $error("laser on while shut off"); // R3
  a_off_fast: assert property ($rose(tx_off_s) |-> ##[1:2] !laser_on) else $error("laser not extinguished"); // R11
  a_on_bound: assert property (on_wait_r < ON_CYC) else $error("laser restore too late"); // R12
  a_fault_clear: assert property ($fell(fault_r) |-> $past(off_cnt_r) == OFF_CNT_MAX && !tx_off_s) // R13
    else $error("fault cleared without pulse");
  a_present_low: assert property (present_oe && !present_o) else $error("presence pin not grounded"); // R5
  a_loss_set: assert property (rx_low_s |=> !lost_oe) else $error("loss not indicated"); // R8
  a_loss_clear: assert property ((rx_ok_s && !rx_low_s) |=> lost_oe) else $error("loss not cleared"); // R14
  a_loss_bound: assert property (loss_wait_r < LOSS_CYC) else $error("loss indication too late"); // R14
  a_addr_ack: assert property ((st_r == TW_ADDR) && scl_fall && (bit_r == BIT_FULL) && addr_hit |=> sda_oe) // R9
    else $error("address not acknowledged");
  a_cal_ext: assert property (cal_ext |=> diag_r[0] == $past(temp_raw)) else $error("external value altered"); // R10
endmodule // ocs_ctrl

// ---- verification/ocs_host.sv ----
// Host board model: line pull-ups and a two-wire master
`timescale 1ns/1ps
module ocs_host (
  input wire logic clk,         // System clock
  input wire logic sda_oe,      // Module pulls data low
  input wire logic fault_oe,    // Module pulls fault line low
  input wire logic lost_oe,     // Module pulls loss line low
  input wire logic present_oe,  // Module grounds presence line
  input wire logic sda_o,       // Module data level while driving
  input wire logic fault_o,     // Module fault level while driving
  input wire logic lost_o,      // Module loss level while driving
  input wire logic present_o,   // Module presence level while driving
  output logic scl,             // Serial clock line
  output logic sda,             // Resolved data line
  output logic fault_ln,        // Resolved fault line
  output logic lost_ln,         // Resolved loss line
  output logic present_ln       // Resolved presence line
);
  // ==========================================================================
  // Line resolution
  // quarter period keeps the clock just under 400 kHz
  localparam int QTR = 63;
  logic scl_r = 1'b1;
  logic sda_lo_r = 1'b0;
  logic [7:0] rd_byte = 8'h00;
  logic ack_bit = 1'b0;
  // host pull-ups, released lines read high
  assign scl = scl_r;
  assign sda = (sda_oe ? sda_o : 1'b1) && !sda_lo_r;
  assign fault_ln = fault_oe ? fault_o : 1'b1;
  assign lost_ln = lost_oe ? lost_o : 1'b1;
  assign present_ln = present_oe ? present_o : 1'b1;

  // ==========================================================================
  // Two-wire master, changes just after a clock edge
  task automatic qwait();
    repeat (QTR) @(posedge clk);
    #1;
  endtask
  // Data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_lo_r = !b;
    qwait();
    scl_r = 1'b1;
    qwait();
    r = sda;
    qwait();
    scl_r = 1'b0;
    qwait();
  endtask
  // Start or repeated start
  task automatic start();
    sda_lo_r = 1'b0;
    qwait();
    scl_r = 1'b1;
    qwait();
    sda_lo_r = 1'b1;
    qwait();
    scl_r = 1'b0;
    qwait();
  endtask
  task automatic stop();
    sda_lo_r = 1'b1;
    qwait();
    scl_r = 1'b1;
    qwait();
    sda_lo_r = 1'b0;
    qwait();
  endtask
  task automatic byte_wr(input logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    ack_bit = !r;
  endtask
  // Last byte of a read is refused to end it
  task automatic byte_rd(input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      rd_byte[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule // ocs_host

// ---- verification/optical_module_ctrl_status_tb.sv ----
// Self-checking bench for the optical module control and status logic
`timescale 1ns/1ps
module optical_module_ctrl_status_tb;
  import ocs_pkg::*;
  logic clk, nrst, tx_off_en, tx_off_val, fault_cond, rx_low, rx_ok, cal_ext;
  logic [15:0] slope;
  logic [15:0] mon [5];
  logic [7:0] d [2];
  wire logic tx_off_pin, laser_on, fault_oe, lost_oe, present_oe, sda_oe, scl, sda, fault_ln, lost_ln, present_ln;
  wire logic sda_o, fault_o, lost_o, present_o;
  int bad_count = 0;
  int samples_checked = 0;
  int sel = 0;
  int n;
  logic [7:0] exp_q [$];
  event sample_ev;
  assign tx_off_pin = tx_off_en ? tx_off_val : 1'b1;

  ocs_ctrl DUT (.clk(clk), .nrst(nrst), .tx_off_i(tx_off_pin), .fault_cond_i(fault_cond), .rx_low_i(rx_low),
    .rx_ok_i(rx_ok), .laser_on(laser_on), .fault_o(fault_o), .fault_oe(fault_oe), .lost_o(lost_o),
    .lost_oe(lost_oe), .present_o(present_o), .present_oe(present_oe), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe),
    .cal_ext(cal_ext), .cal_slope(slope), .temp_raw(mon[0]), .vcc_raw(mon[1]), .bias_raw(mon[2]),
    .txpwr_raw(mon[3]), .rxpwr_raw(mon[4]));
  ocs_host host (.clk(clk), .sda_oe(sda_oe), .fault_oe(fault_oe), .lost_oe(lost_oe), .present_oe(present_oe),
    .sda_o(sda_o), .fault_o(fault_o), .lost_o(lost_o), .present_o(present_o),
    .scl(scl), .sda(sda), .fault_ln(fault_ln), .lost_ln(lost_ln), .present_ln(present_ln));

  // ==========================================================================
  // Observation and comparison
  function automatic logic [7:0] probe(input int c);
    case (c)
      0: return {7'h00, laser_on};
      1: return {7'h00, fault_ln};
      2: return {7'h00, lost_ln};
      3: return {7'h00, present_ln};
      4: return host.rd_byte;
      5: return {7'h00, host.ack_bit};
      default: return 8'hFF;
    endcase
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Watcher takes the oldest note whenever a result is announced
  always @(sample_ev) begin
    if (exp_q.size() > 0) check(probe(sel), exp_q.pop_front());
  end
  // Bounded wait for a result, then hand the note to the watcher
  task automatic expect_sig(input int c, input logic [7:0] e, input int lim);
    int k;
    k = 0;
    while (probe(c) !== e && k < lim) begin
      @(posedge clk);
      #1;
      k++;
    end
    exp_q.push_back(e);
    sel = c;
    ->sample_ev;
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] v, input logic ack);
    host.byte_wr(v);
    expect_sig(5, {7'h00, ack}, 0);
  endtask
  task automatic rd(input logic [7:0] e, input logic last);
    host.byte_rd(last);
    expect_sig(4, e, 0);
  endtask
  // Diagnostic byte i, high byte first, zero beyond the area
  function automatic logic [7:0] diag_byte(input int i);
    logic [31:0] p;
    logic [15:0] v;
    p = {16'h0000, mon[i/2 % 5]} * {16'h0000, slope};
    v = cal_ext ? mon[i/2 % 5] : p[23:8];
    return (i >= 10) ? 8'h00 : ((i % 2) ? v[7:0] : v[15:8]);
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ==========================================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (95000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end

  // ==========================================================================
  // Tests
  initial begin
    nrst = 1'b0;
    tx_off_en = 1'b0;
    tx_off_val = 1'b0;
    fault_cond = 1'b0;
    rx_low = 1'b0;
    rx_ok = 1'b0;
    cal_ext = 1'b1;
    slope = CAL_SLOPE_RST;
    foreach (mon[i]) mon[i] = 16'h0000;
    n = $urandom(32'h00D5);
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    expect_sig(3, 8'h00, 0);
    expect_sig(0, 8'h00, 0);
    expect_sig(2, 8'h01, 0);
    rx_ok = 1'b1;
    expect_sig(2, 8'h00, T_LOSS_CYC);
    tx_off_en = 1'b1;
    expect_sig(0, 8'h01, T_ON_CYC);
    tx_off_val = 1'b1;
    expect_sig(0, 8'h00, T_OFF_CYC);
    tx_off_val = 1'b0;
    expect_sig(0, 8'h01, T_ON_CYC);
    rx_ok = 1'b0;
    rx_low = 1'b1;
    expect_sig(2, 8'h01, T_LOSS_CYC);
    rx_low = 1'b0;
    rx_ok = 1'b1;
    expect_sig(2, 8'h00, T_LOSS_CYC);
    $display("test status pins done");
    fault_cond = 1'b1;
    expect_sig(1, 8'h01, T_FAULT_CYC);
    expect_sig(0, 8'h00, 0);
    fault_cond = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    expect_sig(1, 8'h01, 0);
    // clearing pulse a little over 10 us
    tx_off_val = 1'b1;
    repeat (T_RESET_CYC + 10) @(posedge clk);
    #1;
    tx_off_val = 1'b0;
    expect_sig(1, 8'h00, 20);
    expect_sig(0, 8'h01, T_ON_CYC);
    $display("test fault latch done");
    foreach (d[i]) d[i] = 8'($urandom());
    host.start();
    wr(8'hA0, 1'b1);
    wr(8'h00, 1'b1);
    foreach (d[i]) wr(d[i], 1'b1);
    host.stop();
    host.start();
    // Writes through the diagnostics address are acknowledged and dropped
    wr(8'hA2, 1'b1);
    wr(8'h00, 1'b1);
    wr(~d[0], 1'b1);
    host.start();
    wr(8'hA0, 1'b1);
    wr(8'h00, 1'b1);
    host.start();
    wr(8'hA1, 1'b1);
    foreach (d[i]) rd(d[i], i == 1);
    host.stop();
    $display("test identification memory done");
    for (int k = 0; k < 2; k++) begin
      cal_ext = (k == 0);
      slope = 16'h0080 + 16'($urandom_range(16'h0200));
      foreach (mon[i]) mon[i] = 16'($urandom());
      n = (k == 0) ? 11 : 2;
      host.start();
      wr(8'hA0, 1'b1);
      wr(8'h00, 1'b1);
      host.start();
      wr(8'hA3, 1'b1);
      for (int i = 0; i < n; i++) rd(diag_byte(i), i == n - 1);
      host.stop();
    end
    $display("test diagnostics done");
    host.start();
    wr(8'hB0, 1'b0);
    host.stop();
    $display("test foreign address done");
    report_and_stop();
  end
endmodule // optical_module_ctrl_status_tb
